// ===== hw/dmsp_cfg.svh
// Purpose: Constants of the dual-mode serial configuration port.
// Assumes: Included by the design files by bare name.
// Notes: Offsets, reset values, field positions and bit counts.
//
// Notes on behaviour
// - Strap high selects I2C, low selects SPI
// - I2C mode: data pin is open-drain SDA
// - 3-wire SPI: data pin carries both directions
// - 4-wire SPI: data pin is input only
// - I2C: high strap pin sets address bit one
// - 4-wire SPI: high strap pin drives read data
// - Serial clock is always an input, host-driven
// - I2C: low strap pin sets address bit zero
// - SPI: select pin is active-low frame select
// - Status change pulls interrupt output low
// - Reset pin returns all logic to known state
// - Reset restores every configuration register default
// - Clock outputs stay disabled throughout reset
`ifndef DMSP_CFG_SVH
`define DMSP_CFG_SVH

// ----------------------------------------
// Mode strap and register indices
// ----------------------------------------
`define DMSP_MODE_I2C 1'b1
`define DMSP_IDX_CTRL 2'h0
`define DMSP_IDX_AUX 2'h1
`define DMSP_IDX_STAT 2'h2

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define DMSP_RST_CTRL 8'h00
`define DMSP_RST_AUX 8'h00
`define DMSP_CTRL_CLKEN 0
`define DMSP_SPI_RD_BIT 7
`define DMSP_I2C_BASE 5'h1a

// ----------------------------------------
// Bit counts
// ----------------------------------------
`define DMSP_CMD_LAST 4'h7
`define DMSP_FRAME_LAST 4'hf
`define DMSP_BYTE_BITS 4'h8

`endif

// ===== hw/dmsp_pkg.sv
// Purpose: Types of the dual-mode serial configuration port.
// Assumes: Compiled before the design modules.
// Notes: One-hot codes written out for the I2C target sequencer.
package dmsp_pkg;

	// ----------------------------------------
	// I2C target states
	// ----------------------------------------
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_ACKA = 7'h04,
		I2C_WR = 7'h08,
		I2C_ACKW = 7'h10,
		I2C_RD = 7'h20,
		I2C_ACKR = 7'h40
	} dmsp_i2c_st_t;

endpackage : dmsp_pkg

// ===== hw/dmsp_sync.sv
// Purpose: Two-stage level synchroniser.
// Assumes: Inputs are levels or slow toggles.
// Notes: First stage feeds only the second.
module dmsp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// Next values: plain shift, no reset on purpose
	always_comb
	begin
		meta_nxt = d;
		q_nxt = meta_r;
	end

	// Two flops in series
	always_ff @(posedge clk)
	begin
		meta_r <= meta_nxt;
		q <= q_nxt;
	end

endmodule : dmsp_sync

// ===== hw/dmsp_port.sv
// Purpose: Strap-selected I2C or SPI configuration port.
// Assumes: dmsp_cfg.svh and dmsp_pkg compiled first.
// Notes: SPI bit logic runs on the serial clock; I2C oversamples.
`include "dmsp_cfg.svh"

module dmsp_port (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic i2c_sel_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_high_or_data_out_pin_in,
	output logic addr_high_or_data_out_pin_out,
	output logic addr_high_or_data_out_pin_oe,
	input wire logic addr_low_or_select_pin,
	input wire logic device_reset_n,
	input wire logic spi_3wire,
	input wire logic [7:0] dev_status,
	output logic status_change_irq_n,
	output logic clk_out_en,
	output logic [7:0] cfg_aux
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [5:0] pin_s;
	logic [1:0] lk_mode;
	logic tgl_s;
	logic lk_tgl_r;
	logic sel_s, sda_s, a1_s, a0_s, drst_n_s, scl_s;

	// Sclk is also sampled here for the I2C oversampler
	dmsp_sync #(.W(6)) u_sync_sys (
		.clk(sys_clk),
		.d({i2c_sel_pin, sda_in, addr_high_or_data_out_pin_in,
			addr_low_or_select_pin, device_reset_n, sclk}),
		.q(pin_s)
	);

	// Mode levels seen by the serial-clock logic
	dmsp_sync #(.W(2)) u_sync_lnk (
		.clk(sclk),
		.d({i2c_sel_pin, spi_3wire}),
		.q(lk_mode)
	);

	// Frame-done toggle back into the system clock
	dmsp_sync #(.W(1)) u_sync_tgl (
		.clk(sys_clk),
		.d(lk_tgl_r),
		.q(tgl_s)
	);

	assign {sel_s, sda_s, a1_s, a0_s, drst_n_s, scl_s} = pin_s;

	// ----------------------------------------
	// Reset and strap capture
	// ----------------------------------------
	logic rst_all;
	logic mode_r, mode_nxt;
	logic [1:0] addr_r, addr_nxt;
	logic link_rst_r, link_rst_nxt;

	// Pin reset acts like a full power-on reset
	assign rst_all = srst | ~drst_n_s;

	// Straps are caught while reset holds, frozen after
	always_comb
	begin
		mode_nxt = rst_all ? sel_s : mode_r;
		addr_nxt = rst_all ? {a1_s, a0_s} : addr_r;
		link_rst_nxt = rst_all;
	end

	always_ff @(posedge sys_clk)
	begin
		mode_r <= mode_nxt;
		addr_r <= addr_nxt;
		link_rst_r <= link_rst_nxt;
	end

	// ----------------------------------------
	// SPI shifter on the serial clock
	// ----------------------------------------
	logic lk_i2c, lk_3w, lk_clr;
	logic [3:0] lk_cnt_r, lk_cnt_nxt;
	logic [14:0] lk_sh_r, lk_sh_nxt;
	logic lk_rd_r, lk_rd_nxt;
	logic [15:0] lk_word_r, lk_word_nxt;
	logic lk_tgl_nxt;
	logic [7:0] rd_buf_r;

	assign lk_i2c = lk_mode[1];
	assign lk_3w = lk_mode[0];
	// Deselect ends the frame; no sclk edge is needed for that
	assign lk_clr = addr_low_or_select_pin | link_rst_r;

	// Sclk is never driven here, only received
	always_comb
	begin
		lk_cnt_nxt = lk_cnt_r;
		lk_sh_nxt = lk_sh_r;
		lk_rd_nxt = lk_rd_r;
		lk_word_nxt = lk_word_r;
		lk_tgl_nxt = lk_tgl_r;
		if (!lk_i2c)
		begin
			lk_sh_nxt = {lk_sh_r[13:0], sda_in};
			lk_cnt_nxt = lk_cnt_r + 4'h1;
			if (lk_cnt_r == `DMSP_CMD_LAST)
				lk_rd_nxt = lk_sh_r[6];
			if (lk_cnt_r == `DMSP_FRAME_LAST)
			begin
				lk_word_nxt = {lk_sh_r, sda_in};
				lk_tgl_nxt = ~lk_tgl_r;
			end
		end
	end

	// Bit state dies with the select
	always_ff @(posedge sclk or posedge lk_clr)
	begin
		if (lk_clr)
		begin
			lk_cnt_r <= 4'h0;
			lk_sh_r <= 15'h0000;
			lk_rd_r <= 1'b0;
		end
		else
		begin
			lk_cnt_r <= lk_cnt_nxt;
			lk_sh_r <= lk_sh_nxt;
			lk_rd_r <= lk_rd_nxt;
		end
	end

	// Word and toggle must outlive the select
	always_ff @(posedge sclk or posedge link_rst_r)
	begin
		if (link_rst_r)
		begin
			lk_word_r <= 16'h0000;
			lk_tgl_r <= 1'b0;
		end
		else
		begin
			lk_word_r <= lk_word_nxt;
			lk_tgl_r <= lk_tgl_nxt;
		end
	end

	// ----------------------------------------
	// SPI read data out, falling edge
	// ----------------------------------------
	logic sdo_r, sdo_nxt;
	logic oe_a1_r, oe_a1_nxt;
	logic oe_sda_r, oe_sda_nxt;
	logic lk_out_ph;

	// Data phase of a read frame: counts 8 to 15
	assign lk_out_ph = lk_rd_r & lk_cnt_r[3] & ~lk_i2c;

	// Rd_buf is settled long before this frame's data phase
	always_comb
	begin
		sdo_nxt = lk_out_ph ? rd_buf_r[~lk_cnt_r[2:0]] : 1'b0;
		oe_a1_nxt = lk_out_ph & ~lk_3w;
		oe_sda_nxt = lk_out_ph & lk_3w;
	end

	always_ff @(negedge sclk or posedge lk_clr)
	begin
		if (lk_clr)
		begin
			sdo_r <= 1'b0;
			oe_a1_r <= 1'b0;
			oe_sda_r <= 1'b0;
		end
		else
		begin
			sdo_r <= sdo_nxt;
			oe_a1_r <= oe_a1_nxt;
			oe_sda_r <= oe_sda_nxt;
		end
	end

	// ----------------------------------------
	// Register file and status change flag
	// ----------------------------------------
	logic tgl_prev_r, spi_go;
	logic acc_wr, acc_rd, i2c_wr, i2c_ld;
	logic [1:0] acc_idx, iptr_r;
	logic [7:0] acc_dat, ish_r;
	logic [7:0] ctrl_r, ctrl_nxt, aux_r, aux_nxt, rd_buf_nxt;
	logic [7:0] stat_prev_r, stat_prev_nxt;
	logic chg_r, chg_nxt, clk_en_r, clk_en_nxt, irq_n_r, irq_n_nxt;

	// Read view shared by both protocols
	function automatic logic [7:0] rd_mux(input logic [1:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == `DMSP_IDX_CTRL)
			v = ctrl_r;
		else if (idx == `DMSP_IDX_AUX)
			v = aux_r;
		else if (idx == `DMSP_IDX_STAT)
			v = dev_status;
		return v;
	endfunction : rd_mux

	// Frames arriving in I2C mode are dropped
	assign spi_go = (tgl_s ^ tgl_prev_r) & ~mode_r;
	assign acc_wr = (spi_go & ~lk_word_r[8 + `DMSP_SPI_RD_BIT]) | i2c_wr;
	assign acc_rd = (spi_go & lk_word_r[8 + `DMSP_SPI_RD_BIT]) | i2c_ld;
	assign acc_idx = spi_go ? lk_word_r[9:8] : iptr_r;
	assign acc_dat = spi_go ? lk_word_r[7:0] : ish_r;

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		aux_nxt = aux_r;
		rd_buf_nxt = rd_buf_r;
		if (acc_wr && acc_idx == `DMSP_IDX_CTRL)
			ctrl_nxt = acc_dat;
		if (acc_wr && acc_idx == `DMSP_IDX_AUX)
			aux_nxt = acc_dat;
		if (spi_go)
			rd_buf_nxt = rd_mux(acc_idx);
		stat_prev_nxt = dev_status;
		// Set wins over the clear by a status read
		chg_nxt = (dev_status != stat_prev_r) |
			(chg_r & ~(acc_rd && acc_idx == `DMSP_IDX_STAT));
		irq_n_nxt = ~chg_nxt;
		clk_en_nxt = ctrl_nxt[`DMSP_CTRL_CLKEN];
		if (rst_all)
		begin
			ctrl_nxt = `DMSP_RST_CTRL;
			aux_nxt = `DMSP_RST_AUX;
			rd_buf_nxt = 8'h00;
			chg_nxt = 1'b0;
			irq_n_nxt = 1'b1;
			clk_en_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		tgl_prev_r <= srst ? 1'b0 : tgl_s;
		ctrl_r <= ctrl_nxt;
		aux_r <= aux_nxt;
		rd_buf_r <= rd_buf_nxt;
		stat_prev_r <= stat_prev_nxt;
		chg_r <= chg_nxt;
		irq_n_r <= irq_n_nxt;
		clk_en_r <= clk_en_nxt;
	end

	// ----------------------------------------
	// I2C target, oversampled
	// ----------------------------------------
	dmsp_pkg::dmsp_i2c_st_t ist_r, ist_nxt;
	logic scl_prev_r, sda_prev_r, rise, fall, start, stop;
	logic [3:0] icnt_r, icnt_nxt;
	logic [7:0] ish_nxt, itx_r, itx_nxt, ibyte;
	logic [1:0] iptr_nxt;
	logic irw_r, irw_nxt, ifirst_r, ifirst_nxt, ioe_r, ioe_nxt;

	assign rise = scl_s & ~scl_prev_r;
	assign fall = ~scl_s & scl_prev_r;
	assign start = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
	assign stop = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
	// Function reads registers too, so a plain assign could go stale
	always_comb
	begin
		ibyte = rd_mux(iptr_r);
	end

	always_comb
	begin
		ist_nxt = ist_r;
		icnt_nxt = icnt_r;
		ish_nxt = ish_r;
		itx_nxt = itx_r;
		iptr_nxt = iptr_r;
		irw_nxt = irw_r;
		ifirst_nxt = ifirst_r;
		ioe_nxt = ioe_r;
		i2c_wr = 1'b0;
		i2c_ld = 1'b0;
		if (rise)
		begin
			ish_nxt = {ish_r[6:0], sda_s};
			icnt_nxt = icnt_r + 4'h1;
		end
		if (mode_r != `DMSP_MODE_I2C || stop)
		begin
			ist_nxt = dmsp_pkg::I2C_IDLE;
			ioe_nxt = 1'b0;
		end
		else if (start)
		begin
			ist_nxt = dmsp_pkg::I2C_ADDR;
			icnt_nxt = 4'h0;
			ioe_nxt = 1'b0;
		end
		else
		begin
			unique case (ist_r)
				dmsp_pkg::I2C_IDLE:
					ioe_nxt = 1'b0;
				dmsp_pkg::I2C_ADDR:
					if (fall && icnt_r == `DMSP_BYTE_BITS)
					begin
						// Strap bits form the two low address bits
						if (ish_r[7:1] == {`DMSP_I2C_BASE, addr_r})
						begin
							ist_nxt = dmsp_pkg::I2C_ACKA;
							ioe_nxt = 1'b1;
							irw_nxt = ish_r[0];
						end
						else
							ist_nxt = dmsp_pkg::I2C_IDLE;
					end
				dmsp_pkg::I2C_ACKA, dmsp_pkg::I2C_ACKR:
					if (rise && ist_r == dmsp_pkg::I2C_ACKR && sda_s)
						ist_nxt = dmsp_pkg::I2C_IDLE;
					else if (fall && ist_r == dmsp_pkg::I2C_ACKA && !irw_r)
					begin
						ist_nxt = dmsp_pkg::I2C_WR;
						ioe_nxt = 1'b0;
						icnt_nxt = 4'h0;
						ifirst_nxt = 1'b1;
					end
					else if (fall)
					begin
						// Load next byte, pull low for a zero bit
						ist_nxt = dmsp_pkg::I2C_RD;
						i2c_ld = 1'b1;
						itx_nxt = ibyte;
						ioe_nxt = ~ibyte[7];
						iptr_nxt = iptr_r + 2'h1;
						icnt_nxt = 4'h0;
					end
				dmsp_pkg::I2C_WR:
					if (fall && icnt_r == `DMSP_BYTE_BITS)
					begin
						ist_nxt = dmsp_pkg::I2C_ACKW;
						ioe_nxt = 1'b1;
						ifirst_nxt = 1'b0;
						if (ifirst_r)
							iptr_nxt = ish_r[1:0];
						else
						begin
							i2c_wr = 1'b1;
							iptr_nxt = iptr_r + 2'h1;
						end
					end
				dmsp_pkg::I2C_ACKW:
					if (fall)
					begin
						ist_nxt = dmsp_pkg::I2C_WR;
						ioe_nxt = 1'b0;
						icnt_nxt = 4'h0;
					end
				dmsp_pkg::I2C_RD:
					if (fall && icnt_r == `DMSP_BYTE_BITS)
					begin
						ist_nxt = dmsp_pkg::I2C_ACKR;
						ioe_nxt = 1'b0;
					end
					else if (fall)
					begin
						itx_nxt = {itx_r[6:0], 1'b0};
						ioe_nxt = ~itx_r[6];
					end
				default:
				begin
					ist_nxt = dmsp_pkg::I2C_IDLE;
					ioe_nxt = 1'b0;
				end
			endcase
		end
		if (rst_all)
		begin
			ist_nxt = dmsp_pkg::I2C_IDLE;
			ioe_nxt = 1'b0;
			iptr_nxt = 2'h0;
			icnt_nxt = 4'h0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		scl_prev_r <= scl_s;
		sda_prev_r <= sda_s;
		ist_r <= ist_nxt;
		icnt_r <= icnt_nxt;
		ish_r <= ish_nxt;
		itx_r <= itx_nxt;
		iptr_r <= iptr_nxt;
		irw_r <= irw_nxt;
		ifirst_r <= ifirst_nxt;
		ioe_r <= ioe_nxt;
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// The data pin owner changes only with the reset strap, so a static
	// select between two flops is safe here.
	assign sda_out = sdo_r;
	assign sda_oe = mode_r ? ioe_r : oe_sda_r;
	assign addr_high_or_data_out_pin_out = sdo_r;
	assign addr_high_or_data_out_pin_oe = oe_a1_r;
	assign status_change_irq_n = irq_n_r;
	assign clk_out_en = clk_en_r;
	assign cfg_aux = aux_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	property p_mode_strap;
		rst_all |=> mode_r == $past(sel_s);
	endproperty
	a_mode_strap: assert property (p_mode_strap)
		else $error("mode not taken from strap");

	property p_clk_off;
		rst_all |=> !clk_out_en;
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("clock outputs on during reset");

	property p_cfg_dflt;
		rst_all |=> ctrl_r == `DMSP_RST_CTRL && cfg_aux == `DMSP_RST_AUX;
	endproperty
	a_cfg_dflt: assert property (p_cfg_dflt)
		else $error("configuration not at default");

	property p_irq;
		(!rst_all && dev_status != stat_prev_r) |=> !status_change_irq_n;
	endproperty
	a_irq: assert property (p_irq)
		else $error("status change without interrupt");

	property p_i2c_od;
		(mode_r == `DMSP_MODE_I2C && !rst_all) |->
			!sda_out && !addr_high_or_data_out_pin_oe;
	endproperty
	a_i2c_od: assert property (p_i2c_od)
		else $error("I2C mode drives data high or strap pin");

	property p_desel;
		(a0_s && $past(a0_s, 2) && mode_r != `DMSP_MODE_I2C) |->
			!sda_oe && !addr_high_or_data_out_pin_oe;
	endproperty
	a_desel: assert property (p_desel)
		else $error("output driven while deselected");

	property p_addr_miss;
		(ist_r == dmsp_pkg::I2C_ADDR && fall && !start && !stop &&
			icnt_r == `DMSP_BYTE_BITS && !rst_all &&
			ish_r[7:1] != {`DMSP_I2C_BASE, addr_r}) |=>
			ist_r == dmsp_pkg::I2C_IDLE ##1 !ioe_r;
	endproperty
	a_addr_miss: assert property (p_addr_miss)
		else $error("foreign I2C address acknowledged");

	property p_rst_idle;
		rst_all |=> ist_r == dmsp_pkg::I2C_IDLE && !ioe_r;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("I2C target busy after reset");

	property p_spi_pins;
		@(posedge sclk) disable iff (lk_clr)
		(lk_3w || lk_i2c) |-> !oe_a1_r ##1 (!lk_3w || lk_i2c || !oe_a1_r);
	endproperty
	a_spi_pins: assert property (p_spi_pins)
		else $error("strap pin driven outside 4-wire SPI");

	property p_sdi_only;
		@(posedge sclk) disable iff (lk_clr)
		(!lk_3w && !lk_i2c) |-> !oe_sda_r;
	endproperty
	a_sdi_only: assert property (p_sdi_only)
		else $error("data pin driven in 4-wire SPI");

endmodule : dmsp_port

// ===== tb/dmsp_host.sv
// Purpose: Host controller model for the dual-mode configuration port.
// Assumes: The bench resolves the pins from both parties' enables.
// Notes: SPI clock idles low between frames; I2C lines released high.
module dmsp_host (
	output logic sclk,
	output logic cs_n,
	output logic h_val,
	output logic h_en,
	input wire logic sda_w,
	input wire logic so_w
);
	timeunit 1ns;
	timeprecision 100ps;

	// Quarter of an I2C bit, slow enough for the oversampler
	localparam int Q = 50;

	// ----------------------------------------
	// Idle pin levels
	// ----------------------------------------
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		h_val = 1'b0;
		h_en = 1'b1;
	end

	// ----------------------------------------
	// SPI frame
	// ----------------------------------------
	// MSB first; sel low sends the clocks with the select left high
	task automatic spi_frame(input logic [15:0] f, input bit tw,
		input int hp, input bit sel, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		cs_n = !sel;
		#(hp);
		for (i = 15; i >= 0; i--)
		begin
			// Let go of the shared line while read data comes back
			h_en = !(tw && f[15] && i < 8);
			h_val = f[i];
			#(hp) sclk = 1'b1;
			if (i < 8)
				rd[i] = tw ? sda_w : so_w;
			#(hp) sclk = 1'b0;
		end
		h_en = 1'b1;
		#(hp) cs_n = 1'b1;
		// Gap lets the read buffer settle in the system domain
		#80;
	endtask : spi_frame

	// ----------------------------------------
	// I2C bit level
	// ----------------------------------------
	task automatic i2c_start();
		h_val = 1'b1;
		sclk = 1'b1;
		#(Q) h_val = 1'b0;
		#(Q) sclk = 1'b0;
		#(Q);
	endtask : i2c_start

	task automatic i2c_stop();
		h_val = 1'b0;
		#(Q) sclk = 1'b1;
		#(Q) h_val = 1'b1;
		#(Q);
	endtask : i2c_stop

	// Eight bits then a released ninth for the acknowledge
	// Sending all ones releases the line, so rb then holds read data
	task automatic i2c_byte(input logic [7:0] b, output logic nak,
		output logic [7:0] rb);
		int i;
		nak = 1'b1;
		rb = 8'h00;
		for (i = 8; i >= 0; i--)
		begin
			h_val = (i > 0) ? b[i-1] : 1'b1;
			#(Q) sclk = 1'b1;
			#(Q) nak = sda_w;
			if (i > 0)
				rb[i-1] = sda_w;
			#(Q) sclk = 1'b0;
			#(Q);
		end
	endtask : i2c_byte
endmodule : dmsp_host

// ===== tb/tb.sv
// Purpose: Self-checking bench for the dual-mode configuration port.
// Assumes: Header, package, design and host model compiled first.
// Notes: Integer model tracks registers and the one-deep read pipeline.
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin errors++; \
	$display("ERROR %0t: got %h want %h", $time, g, w); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, srst, i2c, three, a1, rst_n, nak;
	logic sclk, cs_n, h_val, h_en, sda_w, ah_w, sda_last, ah_last;
	logic sda_out, sda_oe, ao_out, ao_oe, irq_n, clk_out_en;
	logic [7:0] dev_status, cfg_aux, d, junk;
	logic [7:0] seq [5] = '{8'h81, 8'h80, 8'h82, 8'h83, 8'h81};
	logic [7:0] wr [4];
	int errors, checked, m_ctrl, m_aux, m_rd, m_ok, hp, t, k;

	// ----------------------------------------
	// Pin resolution
	// ----------------------------------------
	// Undriven SPI lines flip each cycle so stale data cannot pass
	assign sda_w = i2c ? !((sda_oe && !sda_out) || !h_val)
		: (sda_oe ? sda_out : (h_en ? h_val : !sda_last));
	assign ah_w = ao_oe ? ao_out : (i2c ? a1 : !ah_last);

	always @(posedge sys_clk)
	begin
		sda_last <= sda_w;
		ah_last <= ah_w;
	end

	dmsp_port dmsp_port_i (
		.sys_clk(sys_clk),
		.srst(srst),
		.sclk(sclk),
		.i2c_sel_pin(i2c),
		.sda_in(sda_w),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.addr_high_or_data_out_pin_in(ah_w),
		.addr_high_or_data_out_pin_out(ao_out),
		.addr_high_or_data_out_pin_oe(ao_oe),
		.addr_low_or_select_pin(i2c ? 1'b0 : cs_n),
		.device_reset_n(rst_n),
		.spi_3wire(three),
		.dev_status(dev_status),
		.status_change_irq_n(irq_n),
		.clk_out_en(clk_out_en),
		.cfg_aux(cfg_aux)
	);

	dmsp_host dmsp_host_i (
		.sclk(sclk),
		.cs_n(cs_n),
		.h_val(h_val),
		.h_en(h_en),
		.sda_w(sda_w),
		.so_w(ah_w)
	);

	// ----------------------------------------
	// Model and tasks
	// ----------------------------------------
	function automatic int m_read(input logic [1:0] idx);
		case (idx)
			2'h0: return m_ctrl;
			2'h1: return m_aux;
			2'h2: return int'(dev_status);
			default: return 0;
		endcase
	endfunction : m_read

	// One frame; a read returns what the previous frame loaded
	task automatic spi(input logic [7:0] c, input logic [7:0] v);
		logic [7:0] r;
		@(posedge sys_clk);
		#0.5 dmsp_host_i.spi_frame({c, v}, three, hp, 1'b1, r);
		if (c[7] && m_ok)
			`CHK(r, m_rd[7:0])
		// Every frame reloads the read buffer, ahead of its own write
		m_rd = m_read(c[1:0]);
		m_ok = 1;
		if (!c[7] && c[1:0] == 2'h0)
			m_ctrl = v;
		else if (!c[7] && c[1:0] == 2'h1)
			m_aux = v;
		`CHK(cfg_aux, m_aux[7:0])
		`CHK(clk_out_en, m_ctrl[0])
	endtask : spi

	task automatic tally_and_finish();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// Clock, watchdog, pin monitor
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial
	begin
		#500000;
		errors++;
		tally_and_finish();
	end

	// Pin enables must stay off outside their modes and frames
	always @(posedge sys_clk)
		if (!srst)
		begin
			if (!i2c && !three)
				`CHK(sda_oe, 1'b0)
			if (i2c || three || cs_n)
				`CHK(ao_oe, 1'b0)
		end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		srst = 1'b1;
		i2c = 1'b0;
		three = 1'b0;
		a1 = 1'b1;
		rst_n = 1'b1;
		dev_status = 8'h00;
		void'($urandom(22));
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		// 4-wire, then 3-wire, both on the 6 ns link clock
		for (t = 0; t < 2; t++)
		begin
			@(posedge sys_clk);
			three <= t[0];
			hp = 3;
			d = 8'($urandom_range(255));
			@(posedge sys_clk);
			#0.5 dmsp_host_i.spi_frame({8'h01, ~d}, 1'b0, hp, 1'b0, junk);
			`CHK(cfg_aux, m_aux[7:0])
			spi(8'h01, d);
			spi(8'h00, 8'h01);
			spi(8'h02, ~d);
			spi(8'h03, d);
			for (k = 0; k < 5; k++)
				spi(seq[k], 8'h00);
			@(posedge sys_clk);
			dev_status <= dev_status ^ (d | 8'h01);
			repeat (3) @(posedge sys_clk);
			`CHK(irq_n, 1'b0)
			spi(8'h82, 8'h00);
			`CHK(irq_n, 1'b1)
		end
		// Reset pin with a status change pending
		@(posedge sys_clk);
		dev_status <= dev_status + 8'h01;
		rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		`CHK(clk_out_en, 1'b0)
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		`CHK(cfg_aux, 8'h00)
		`CHK(irq_n, 1'b1)
		m_ctrl = 0;
		m_aux = 0;
		// Strap to I2C; mode and address caught during reset
		i2c <= 1'b1;
		srst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		wr = '{8'hd4, 8'h00, 8'h01, d};
		#0.5 dmsp_host_i.i2c_start();
		for (k = 0; k < 4; k++)
		begin
			dmsp_host_i.i2c_byte(wr[k], nak, junk);
			`CHK(nak, 1'b0)
		end
		dmsp_host_i.i2c_stop();
		`CHK(clk_out_en, 1'b1)
		`CHK(cfg_aux, d)
		// Pointer to aux, repeated start, read it back with a NACK
		dmsp_host_i.i2c_start();
		dmsp_host_i.i2c_byte(8'hd4, nak, junk);
		dmsp_host_i.i2c_byte(8'h01, nak, junk);
		dmsp_host_i.i2c_start();
		dmsp_host_i.i2c_byte(8'hd5, nak, junk);
		`CHK(nak, 1'b0)
		dmsp_host_i.i2c_byte(8'hff, nak, junk);
		`CHK(junk, d)
		dmsp_host_i.i2c_stop();
		// Address with one strap bit wrong must not be answered
		for (k = 0; k < 2; k++)
		begin
			dmsp_host_i.i2c_start();
			dmsp_host_i.i2c_byte(k[0] ? 8'hd0 : 8'hd6, nak, junk);
			`CHK(nak, 1'b1)
			dmsp_host_i.i2c_stop();
		end
		tally_and_finish();
	end
endmodule : tb
